// [verilog/porst_cfg.svh]
/*
 * Constants of the power-on reset state block: register offsets, reset values,
 * field positions and timing counts.
 * Assumes inclusion by bare name from the design module and the test bench.
 */
`ifndef PORST_CFG_SVH
`define PORST_CFG_SVH

// register byte offsets on the APB slave
`define PORST_CPU_CTRL_OFF 12'h000
`define PORST_USB_CTRL_OFF 12'h004
`define PORST_FUNC_ADDR_OFF 12'h008
`define PORST_BINVAL_OFF 12'h00C
`define PORST_BOUTVAL_OFF 12'h010
`define PORST_ISOINVAL_OFF 12'h014
`define PORST_ISOOUTVAL_OFF 12'h018
`define PORST_PAIR_OFF 12'h01C
`define PORST_BAV_OFF 12'h020
`define PORST_PORTCFG_OFF 12'h024
`define PORST_PORTOE_OFF 12'h028
`define PORST_IEN_OFF 12'h02C
`define PORST_IRQ_OFF 12'h030
`define PORST_TOGGLE_OFF 12'h034
`define PORST_CONFIG_OFF 12'h038
`define PORST_STATUS_OFF 12'h03C
`define PORST_EPCS_BASE 12'h040
`define PORST_EPCS_LAST 12'h07C

// reset values
`define PORST_CPU_CTRL_RST 4'h3
`define PORST_USB_CTRL_RST 8'h04
`define PORST_ZERO8 8'h00
`define PORST_BINVAL_RST 8'h57
`define PORST_BOUTVAL_RST 8'h55
`define PORST_ISOVAL_RST 8'h07
`define PORST_OUT_ARM 8'h02

// field positions
`define PORST_CPU_CTRL_HOLD 0
`define PORST_CPU_CTRL_CLKOE 1
`define PORST_USB_CTRL_RENUMERATE 1
`define PORST_BAV_BREAK 3
`define PORST_PAIR_ISO0 7

// pll lock wait, in ns, then in pclk cycles (rounded up)
`define PORST_PLL_LOCK_NS 20000
`define PORST_CLK_PERIOD_NS 10
`define PORST_PLL_LOCK_CYC ((`PORST_PLL_LOCK_NS + `PORST_CLK_PERIOD_NS - 1) / `PORST_CLK_PERIOD_NS)

`endif

// [verilog/porst_pkg.sv]
/*
 * Types of the power-on reset state block.
 * Assumes porst_cfg.svh holds the numeric constants.
 */
package porst_pkg;
    typedef enum logic [1:0] {
        ST_POWER_UP,
        ST_HOLD_CPU,
        ST_RUN
    } porst_state_e;
endpackage

// [verilog/porst_top.sv]
/*
 * Power-on reset state logic: holds the core until the pll is stable, drives
 * the clock output, gated by its enable and by suspend, loads reset values of the usb register set,
 * naks bulk tokens while the processor is held and arms bulk OUT endpoints
 * on its release. Registers are reached over APB.
 * Assumes pclk comes from the pll and runs whenever power is present; the
 * reset pin and power-good arrive asynchronously.
 */
// Implementation choices: the register addresses and register access over APB.
// Functional notes
// - core held in reset until pll stable
// - clock out on from power, processor can stop
// - high reset pin forces full chip reset
// - clock runs in reset, stops if suspended
// - bus activity or wake pin restarts clock
// - pin and power reset give same state
// - processor control reads rev, clkoe, hold set
// - port configs and output enables cleared
// - usb interrupt enables and requests cleared
// - bulk endpoint control/status registers cleared
// - nak bulk tokens while processor held
// - arm bulk OUT endpoints on processor release
// - all data toggles cleared
// - usb control reads renumerate 0, disconnect 1
// - function address cleared
// - endpoint valid registers match default device
// - pairing off and iso zero send clear
// - breakpoint and autovector control cleared
// - configuration and alternate setting zero
// - buffers, counts, port data left uninitialised
`timescale 1ns/1ps
`include "porst_cfg.svh"

module porst_top #(
    parameter int PLL_LOCK_CYC = `PORST_PLL_LOCK_CYC,
    parameter logic [3:0] SILICON_REV = 4'h1 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_pin,
    input wire logic wake_pin_n,
    input wire logic usb_activity,
    input wire logic usb_suspend,
    input wire logic bulk_token,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic clock_out_24,
    output logic core_reset,
    output logic processor_reset,
    output logic bulk_nak
);
    // reset pin, wake pin and usb activity synchronisers (three stages)
    logic [2:0] rst_sync_ff;
    logic [2:0] wake_sync_ff;
    logic [2:0] act_sync_ff;
    logic pin_reset_ff;
    logic wake_lvl_ff;
    logic act_lvl_ff;
    logic [$clog2(PLL_LOCK_CYC + 1) - 1:0] lock_cnt_ff;
    porst_pkg::porst_state_e state_ff;
    logic chip_rst;
    logic wr_en;
    logic rd_en;

    // registers
    logic [1:0] cpu_ctrl_ff;
    logic [7:0] usb_ctrl_ff;
    logic [6:0] func_addr_ff;
    logic [7:0] binval_ff;
    logic [7:0] boutval_ff;
    logic [7:0] isoinval_ff;
    logic [7:0] isooutval_ff;
    logic [7:0] pair_ff;
    logic [7:0] bav_ff;
    logic [7:0] portcfg_ff;
    logic [7:0] portoe_ff;
    logic [7:0] ien_ff;
    logic [7:0] irq_ff;
    logic [15:0] toggle_ff;
    logic [7:0] config_ff;
    logic [7:0] epcs_ff [0:15];
    logic clk_run_ff;
    logic div_ff;
    logic hold_prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync_ff <= 3'h7;
            wake_sync_ff <= 3'h7;
            act_sync_ff <= 3'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[1:0], reset_pin};
            wake_sync_ff <= {wake_sync_ff[1:0], wake_pin_n};
            act_sync_ff <= {act_sync_ff[1:0], usb_activity};
        end
    end

    // pin level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reset_ff <= 1'b1;
        end else if (rst_sync_ff[1] == rst_sync_ff[2]) begin
            pin_reset_ff <= rst_sync_ff[2];
        end
    end

    // wake and activity levels count once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_lvl_ff <= 1'b1;
            act_lvl_ff <= 1'b0;
        end else begin
            if (wake_sync_ff[1] == wake_sync_ff[2]) begin
                wake_lvl_ff <= wake_sync_ff[2];
            end
            if (act_sync_ff[1] == act_sync_ff[2]) begin
                act_lvl_ff <= act_sync_ff[2];
            end
        end
    end

    // pll lock wait after power-up; the pin does not restart it since the pll runs on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= porst_pkg::ST_POWER_UP;
            lock_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                porst_pkg::ST_POWER_UP: begin
                    if (lock_cnt_ff == ($bits(lock_cnt_ff))'(PLL_LOCK_CYC - 1)) begin
                        state_ff <= porst_pkg::ST_HOLD_CPU;
                    end else begin
                        lock_cnt_ff <= lock_cnt_ff + 1'b1;
                    end
                end
                porst_pkg::ST_HOLD_CPU: begin
                    if (!pin_reset_ff) begin
                        state_ff <= porst_pkg::ST_RUN;
                    end
                end
                porst_pkg::ST_RUN: begin
                    if (pin_reset_ff) begin
                        state_ff <= porst_pkg::ST_HOLD_CPU;
                    end
                end
            endcase
        end
    end

    // one reset term for power and pin so both load identical values
    assign chip_rst = (state_ff != porst_pkg::ST_RUN);

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= chip_rst;
        end
    end

    // processor control: clock enable and hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ctrl_ff <= 2'(`PORST_CPU_CTRL_RST);
        end else if (chip_rst) begin
            cpu_ctrl_ff <= 2'(`PORST_CPU_CTRL_RST);
        end else if (wr_en && paddr == `PORST_CPU_CTRL_OFF) begin
            cpu_ctrl_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_prev_ff <= 1'b1;
            processor_reset <= 1'b1;
            bulk_nak <= 1'b0;
        end else begin
            hold_prev_ff <= cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD];
            processor_reset <= cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD];
            bulk_nak <= cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD] && bulk_token;
        end
    end

    // clock output: runs in reset, stops in suspend, restarts on activity or wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_run_ff <= 1'b1;
        end else if (chip_rst) begin
            clk_run_ff <= 1'b1;
        end else if (act_lvl_ff || !wake_lvl_ff) begin
            clk_run_ff <= 1'b1;
        end else if (usb_suspend) begin
            clk_run_ff <= 1'b0;
        end
    end

    // divide by two stands in for the 24 MHz output rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 1'b0;
            clock_out_24 <= 1'b0;
        end else begin
            div_ff <= ~div_ff;
            clock_out_24 <= div_ff && clk_run_ff && cpu_ctrl_ff[`PORST_CPU_CTRL_CLKOE];
        end
    end

    // usb register set, reloaded on every chip reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_ctrl_ff <= `PORST_USB_CTRL_RST;
            func_addr_ff <= '0;
            binval_ff <= `PORST_BINVAL_RST;
            boutval_ff <= `PORST_BOUTVAL_RST;
            isoinval_ff <= `PORST_ISOVAL_RST;
            isooutval_ff <= `PORST_ISOVAL_RST;
            pair_ff <= `PORST_ZERO8;
            portcfg_ff <= `PORST_ZERO8;
            portoe_ff <= `PORST_ZERO8;
            ien_ff <= `PORST_ZERO8;
            toggle_ff <= '0;
            config_ff <= `PORST_ZERO8;
        end else if (chip_rst) begin
            usb_ctrl_ff <= `PORST_USB_CTRL_RST;
            func_addr_ff <= '0;
            binval_ff <= `PORST_BINVAL_RST;
            boutval_ff <= `PORST_BOUTVAL_RST;
            isoinval_ff <= `PORST_ISOVAL_RST;
            isooutval_ff <= `PORST_ISOVAL_RST;
            pair_ff <= `PORST_ZERO8;
            portcfg_ff <= `PORST_ZERO8;
            portoe_ff <= `PORST_ZERO8;
            ien_ff <= `PORST_ZERO8;
            toggle_ff <= '0;
            config_ff <= `PORST_ZERO8;
        end else if (wr_en) begin
            unique case (paddr)
                `PORST_USB_CTRL_OFF: usb_ctrl_ff <= pwdata[7:0];
                `PORST_FUNC_ADDR_OFF: func_addr_ff <= pwdata[6:0];
                `PORST_BINVAL_OFF: binval_ff <= pwdata[7:0];
                `PORST_BOUTVAL_OFF: boutval_ff <= pwdata[7:0];
                `PORST_ISOINVAL_OFF: isoinval_ff <= pwdata[7:0];
                `PORST_ISOOUTVAL_OFF: isooutval_ff <= pwdata[7:0];
                `PORST_PAIR_OFF: pair_ff <= pwdata[7:0];
                `PORST_PORTCFG_OFF: portcfg_ff <= pwdata[7:0];
                `PORST_PORTOE_OFF: portoe_ff <= pwdata[7:0];
                `PORST_IEN_OFF: ien_ff <= pwdata[7:0];
                `PORST_TOGGLE_OFF: toggle_ff <= pwdata[15:0];
                `PORST_CONFIG_OFF: config_ff <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // interrupt requests: write one to clear; no hardware sources live in this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= `PORST_ZERO8;
        end else if (chip_rst) begin
            irq_ff <= `PORST_ZERO8;
        end else if (wr_en && paddr == `PORST_IRQ_OFF) begin
            irq_ff <= irq_ff & ~pwdata[7:0];
        end
    end

    // breakpoint/autovector; break also cleared while processor is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bav_ff <= `PORST_ZERO8;
        end else if (chip_rst) begin
            bav_ff <= `PORST_ZERO8;
        end else if (wr_en && paddr == `PORST_BAV_OFF) begin
            bav_ff <= pwdata[7:0];
        end else if (cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD]) begin
            bav_ff[`PORST_BAV_BREAK] <= 1'b0;
        end
    end

    // endpoint cs: entries 0..7 bulk IN, 8..15 bulk OUT
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_epcs
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    epcs_ff[gi] <= `PORST_ZERO8;
                end else if (chip_rst) begin
                    epcs_ff[gi] <= `PORST_ZERO8;
                end else if (gi >= 8 && hold_prev_ff && !cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD]) begin
                    epcs_ff[gi] <= `PORST_OUT_ARM;
                end else if (wr_en && paddr == `PORST_EPCS_BASE + 12'(gi * 4)) begin
                    epcs_ff[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // APB: zero wait, reads registered; unmapped addresses give pslverr
    logic [7:0] rd_val;
    logic hit;
    always_comb begin
        rd_val = `PORST_ZERO8;
        hit = 1'b1;
        if (paddr >= `PORST_EPCS_BASE && paddr <= `PORST_EPCS_LAST && paddr[1:0] == 2'h0) begin
            rd_val = epcs_ff[paddr[5:2]];
        end else begin
            unique case (paddr)
                `PORST_CPU_CTRL_OFF: rd_val = {SILICON_REV, 2'h0, cpu_ctrl_ff};
                `PORST_USB_CTRL_OFF: rd_val = usb_ctrl_ff;
                `PORST_FUNC_ADDR_OFF: rd_val = {1'b0, func_addr_ff};
                `PORST_BINVAL_OFF: rd_val = binval_ff;
                `PORST_BOUTVAL_OFF: rd_val = boutval_ff;
                `PORST_ISOINVAL_OFF: rd_val = isoinval_ff;
                `PORST_ISOOUTVAL_OFF: rd_val = isooutval_ff;
                `PORST_PAIR_OFF: rd_val = pair_ff;
                `PORST_BAV_OFF: rd_val = bav_ff;
                `PORST_PORTCFG_OFF: rd_val = portcfg_ff;
                `PORST_PORTOE_OFF: rd_val = portoe_ff;
                `PORST_IEN_OFF: rd_val = ien_ff;
                `PORST_IRQ_OFF: rd_val = irq_ff;
                `PORST_TOGGLE_OFF: rd_val = toggle_ff[7:0];
                `PORST_CONFIG_OFF: rd_val = config_ff;
                `PORST_STATUS_OFF: rd_val = {6'h00, state_ff};
                default: hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
        end
    end

    // buffers, byte counts and port data are held outside this block

    AST_CLKOUT_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        !cpu_ctrl_ff[`PORST_CPU_CTRL_CLKOE] |=> !clock_out_24)
        else $error("clock out running with enable clear");
    AST_RESET_CPU_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
        chip_rst |=> cpu_ctrl_ff == 2'h3 && usb_ctrl_ff == 8'h04)
        else $error("reset values not loaded");
    AST_RESET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        chip_rst |=> func_addr_ff == 7'h00 && ien_ff == 8'h00 && irq_ff == 8'h00 && portoe_ff == 8'h00)
        else $error("cleared registers not zero after reset");
    AST_CORE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == porst_pkg::ST_POWER_UP |=> core_reset)
        else $error("core released before pll lock wait");
    AST_NAK_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD] && bulk_token |=> bulk_nak)
        else $error("bulk token not naked while processor held");
    AST_NO_NAK_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        !cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD] |=> !bulk_nak)
        else $error("nak given while processor runs");
    AST_ARM_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        !chip_rst && $fell(cpu_ctrl_ff[`PORST_CPU_CTRL_HOLD]) |=> epcs_ff[8] == 8'h02)
        else $error("out endpoint not armed on release");
    AST_SUSPEND_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        !chip_rst && usb_suspend && !act_lvl_ff && wake_lvl_ff |=> !clk_run_ff)
        else $error("clock out kept running in suspend");
    AST_PIN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        pin_reset_ff |=> chip_rst)
        else $error("reset pin did not reset chip");
    AST_CLK_IN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        chip_rst |=> clk_run_ff)
        else $error("clock stopped during reset");
endmodule

// [tb/porst_rst_model.sv]
/*
 * External reset network model: pulls the reset pin high for HOLD cycles.
 * Assumes trig is a one-cycle request from the bench on pclk.
 */
`timescale 1ns/1ps

module porst_rst_model #(
    parameter int HOLD = 40
) (
    input wire logic pclk,
    input wire logic trig,
    output logic reset_pin
);
    int cnt_ff = 0;

    // level pulse, not a glitch: the device synchronises it
    assign reset_pin = (cnt_ff != 0);

    always @(posedge pclk) begin
        if (trig) begin
            cnt_ff <= HOLD;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
endmodule

// [tb/porst_top_test.sv]
/*
 * Self-checking bench of the power-on reset state block.
 * Assumes porst_cfg.svh offsets and reset values; APB master drives on pclk.
 */
`timescale 1ns/1ps
`include "porst_cfg.svh"

module porst_top_test;
    localparam int LOCK = 4;
    localparam logic [3:0] REV = 4'hA; // arbitrary value
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic wake_pin_n = 1'b1;
    logic usb_activity = 1'b0;
    logic usb_suspend = 1'b0;
    logic bulk_token = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic rst_trig = 1'b0;
    logic reset_pin;
    logic [31:0] prdata;
    logic pready, pslverr, clock_out_24, core_reset, processor_reset, bulk_nak;
    int err_total = 0;
    int checks = 0;

    always #5 pclk = ~pclk;

    porst_rst_model #(.HOLD(40)) ext_rst (.pclk(pclk), .trig(rst_trig), .reset_pin(reset_pin));

    porst_top #(.PLL_LOCK_CYC(LOCK), .SILICON_REV(REV)) dut (
        .pclk(pclk), .presetn(presetn), .reset_pin(reset_pin), .wake_pin_n(wake_pin_n),
        .usb_activity(usb_activity), .usb_suspend(usb_suspend), .bulk_token(bulk_token),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_out_24(clock_out_24),
        .core_reset(core_reset), .processor_reset(processor_reset), .bulk_nak(bulk_nak)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        // a missing pready must not pass silently
        if (n >= 20) chk(32'd0, 32'd1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b1, wd, rd, er);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b0, 32'h0, rd, er);
        chk(rd, exp);
    endtask

    task automatic toggles(output int t);
        logic last;
        t = 0;
        // let a change made just before pass the pin synchronisers
        repeat (8) @(posedge pclk);
        last = clock_out_24;
        repeat (16) begin
            @(posedge pclk);
            if (clock_out_24 !== last) t++;
            last = clock_out_24;
        end
    endtask

    task automatic wait_run(output int n);
        n = 0;
        while (core_reset !== 1'b0 && n < 200) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic check_defaults();
        logic [7:0] tbl [15];
        int i;
        tbl = '{{REV, `PORST_CPU_CTRL_RST}, `PORST_USB_CTRL_RST, `PORST_ZERO8, `PORST_BINVAL_RST,
                `PORST_BOUTVAL_RST, `PORST_ISOVAL_RST, `PORST_ISOVAL_RST, 8'h00, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (i = 0; i < 15; i++) begin
            rd_chk(12'(i * 4), {24'h0, tbl[i]});
        end
        for (i = 0; i < 16; i++) begin
            rd_chk(`PORST_EPCS_BASE + 12'(i * 4), 32'h0);
        end
        $display("test defaults done");
    endtask

    task automatic test_nak_arm();
        @(posedge pclk);
        bulk_token <= 1'b1;
        @(posedge pclk);
        bulk_token <= 1'b0;
        #1;
        chk({31'h0, bulk_nak}, 32'h1);
        wr(`PORST_CPU_CTRL_OFF, 32'h02);
        repeat (3) @(posedge pclk);
        #1;
        chk({31'h0, processor_reset}, 32'h0);
        rd_chk(12'h060, {24'h0, `PORST_OUT_ARM});
        rd_chk(`PORST_EPCS_LAST, {24'h0, `PORST_OUT_ARM});
        rd_chk(`PORST_EPCS_BASE, 32'h0);
        @(posedge pclk);
        bulk_token <= 1'b1;
        @(posedge pclk);
        bulk_token <= 1'b0;
        #1;
        chk({31'h0, bulk_nak}, 32'h0);
        $display("test nak and arm done");
    endtask

    task automatic test_clock();
        int t;
        toggles(t);
        chk(32'(t > 0), 32'd1);
        wr(`PORST_CPU_CTRL_OFF, 32'h00);
        toggles(t);
        chk(32'(t), 32'd0);
        wr(`PORST_CPU_CTRL_OFF, 32'h02);
        usb_suspend <= 1'b1;
        toggles(t);
        chk(32'(t), 32'd0);
        usb_activity <= 1'b1;
        toggles(t);
        chk(32'(t > 0), 32'd1);
        usb_activity <= 1'b0;
        toggles(t);
        chk(32'(t), 32'd0);
        wake_pin_n <= 1'b0;
        toggles(t);
        chk(32'(t > 0), 32'd1);
        wake_pin_n <= 1'b1;
        $display("test clock done");
    endtask

    task automatic test_pin_reset();
        int t;
        int n;
        wr(`PORST_FUNC_ADDR_OFF, 32'h55);
        wr(`PORST_IEN_OFF, 32'hFF);
        usb_suspend <= 1'b1;
        @(posedge pclk);
        rst_trig <= 1'b1;
        @(posedge pclk);
        rst_trig <= 1'b0;
        repeat (8) @(posedge pclk);
        #1;
        chk({31'h0, core_reset}, 32'h1);
        chk({31'h0, processor_reset}, 32'h1);
        toggles(t);
        chk(32'(t > 0), 32'd1);
        wait_run(n);
        chk(32'(n < 200), 32'd1);
        toggles(t);
        chk(32'(t), 32'd0);
        usb_suspend <= 1'b0;
        check_defaults();
        $display("test pin reset done");
    endtask

    task automatic test_unmapped();
        logic [31:0] rd;
        logic er;
        apb(12'h080, 1'b0, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("test unmapped done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        int n;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({31'h0, core_reset}, 32'h1);
        wait_run(n);
        chk(32'(n >= LOCK && n < 200), 32'd1);
        check_defaults();
        test_nak_arm();
        test_clock();
        test_pin_reset();
        test_unmapped();
        stop_test();
    end

    // full run needs well under 5000 cycles
    initial begin
        #50000;
        err_total++;
        stop_test();
    end
endmodule
